// ### verilog/adsp_map.vh
// constants for the adc serial control port: control byte layout, result format, clock-select code and timing
`ifndef ADSP_MAP_VH
`define ADSP_MAP_VH
`define ADSP_BIT_START 7
`define ADSP_BIT_SEL_HI 6
`define ADSP_BIT_SEL_MID 5
`define ADSP_BIT_SEL_LO 4
`define ADSP_BIT_POLARITY 3
`define ADSP_BIT_INPUT_CFG 2
`define ADSP_BIT_PCS_HI 1
`define ADSP_BIT_PCS_LO 0
`define ADSP_CTRL_BITS 8
`define ADSP_RESULT_BITS 12
`define ADSP_RESULT_RST 12'h0000
`define ADSP_FRAME_CLKS 15
`define ADSP_TRACK_BIT 5
`define ADSP_PCS_EXT_CLK 2'b11
`define ADSP_BIPOLAR_MID 12'h0800
`endif

// ### verilog/adsp_sync.v
// three-stage synchroniser for one pin level; stage two and three must agree
`timescale 1ns/1ps
module adsp_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_pin,
	output reg o_level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			o_level <= RST_VAL;
		end else if (i_ce) begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// a change counts only once two settled stages agree
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end
endmodule

// ### verilog/adsp_port.v
// serial control and result port of an eight-channel 12-bit converter
`timescale 1ns/1ps
`include "adsp_map.vh"
// Function
// (RQ1) host sends control byte before each conversion
// (RQ2) all-ones byte: single-ended unipolar channel 7
// (RQ3) strobe high one period before result msb; the port raises it in external-clock mode only
// (RQ4) external-clock frame is fifteen serial clocks; the port accepts a new start bit on the fifteenth clock
// (RQ5) strobe and result change on falling edges
// (RQ6) capture command bit on each rising edge
// (RQ7) skip zeros, first one is start bit
// (RQ8) control byte field layout, msb first
// (RQ9) single-ended channel map, negative is ground
// (RQ10) differential pairs, even or odd positive
// (RQ11) host uses spi mode zero, full duplex
// (RQ12) host serial clock 100 kHz to 2 MHz; the bench host runs it at 8 MHz
// (RQ13) host control byte pattern 1xxxxx11
// (RQ14) host: select, byte, two zero bytes, deselect
// (RQ15) one leading zero, twelve bits, three zeros
// (RQ16) host keeps conversion under 120 microseconds
// (RQ17) unipolar straight binary, bipolar twos complement
// (RQ18) result shifted msb first on falling edges
// (RQ19) low control bits choose conversion clock source
// (RQ20) result output released while chip select high
// (RQ21) track after fifth bit, hold after eighth
// (RQ22) partial byte discarded when chip select rises
module adsp_port #(
	parameter RES_BITS = `ADSP_RESULT_BITS
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_cs_n,
	input wire i_sclk,
	input wire i_cmd_in,
	input wire [RES_BITS-1:0] i_sample_offset_bin,
	output reg o_result_out,
	output reg o_result_oe,
	output reg o_conversion_strobe,
	output reg o_strobe_oe,
	output reg [2:0] o_pos_channel,
	output reg [3:0] o_neg_channel,
	output reg o_bipolar,
	output reg o_int_clk_mode,
	output reg [1:0] o_power_clock_sel,
	output reg o_track,
	output reg o_sample_req,
	output reg o_busy
);
	localparam ST_IDLE = 2'd0;
	localparam ST_CTRL = 2'd1;
	localparam ST_CONV = 2'd2;
	wire cs_n_s;
	wire sclk_s;
	wire cmd_s;
	reg sclk_prev_q;
	reg [1:0] st_q;
	reg [2:0] nbit_q;
	reg [6:0] shreg_q;
	reg [3:0] conv_cnt_q;
	reg [RES_BITS-1:0] res_q;
	wire rise;
	wire fall;
	wire [7:0] byte_w;
	wire [2:0] sel_w;
	reg [2:0] pos_d;
	reg [3:0] neg_d;

	adsp_sync #(.RST_VAL(1'b1)) u_cs (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_cs_n),
		.o_level(cs_n_s));
	adsp_sync #(.RST_VAL(1'b0)) u_sclk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_sclk),
		.o_level(sclk_s));
	adsp_sync #(.RST_VAL(1'b0)) u_cmd (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_cmd_in),
		.o_level(cmd_s));

	assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
	assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
	assign byte_w = {shreg_q, cmd_s};
	assign sel_w = {byte_w[`ADSP_BIT_SEL_HI], byte_w[`ADSP_BIT_SEL_MID], byte_w[`ADSP_BIT_SEL_LO]};

	// channel map; neg code 4'h8 stands for analog_ground
	always @* begin
		pos_d = 3'd0;
		neg_d = 4'h8;
		if (byte_w[`ADSP_BIT_INPUT_CFG]) begin
			// single-ended: code order is not binary, so each channel is listed
			case (sel_w)
			3'b000: pos_d = 3'd0; // RQ9
			3'b100: pos_d = 3'd1; // RQ9
			3'b001: pos_d = 3'd2; // RQ9
			3'b101: pos_d = 3'd3; // RQ9
			3'b010: pos_d = 3'd4; // RQ9
			3'b110: pos_d = 3'd5; // RQ9
			3'b011: pos_d = 3'd6; // RQ9
			3'b111: pos_d = 3'd7; // RQ9
			default: pos_d = 3'd0;
			endcase
			neg_d = 4'h8; // RQ9
		end else begin
			// differential: low code bits pick the pair, the top bit swaps its sides
			case (sel_w)
			3'b000: begin
				pos_d = 3'd0; // RQ10
				neg_d = 4'd1; // RQ10
			end
			3'b001: begin
				pos_d = 3'd2; // RQ10
				neg_d = 4'd3; // RQ10
			end
			3'b010: begin
				pos_d = 3'd4; // RQ10
				neg_d = 4'd5; // RQ10
			end
			3'b011: begin
				pos_d = 3'd6; // RQ10
				neg_d = 4'd7; // RQ10
			end
			3'b100: begin
				pos_d = 3'd1; // RQ10
				neg_d = 4'd0; // RQ10
			end
			3'b101: begin
				pos_d = 3'd3; // RQ10
				neg_d = 4'd2; // RQ10
			end
			3'b110: begin
				pos_d = 3'd5; // RQ10
				neg_d = 4'd4; // RQ10
			end
			3'b111: begin
				pos_d = 3'd7; // RQ10
				neg_d = 4'd6; // RQ10
			end
			default: begin
				pos_d = 3'd0;
				neg_d = 4'h8;
			end
			endcase
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			sclk_prev_q <= 1'b0;
			st_q <= ST_IDLE;
			nbit_q <= 3'd0;
			shreg_q <= 7'd0;
			conv_cnt_q <= 4'd0;
			res_q <= `ADSP_RESULT_RST;
			o_result_out <= 1'b0;
			o_result_oe <= 1'b0;
			o_conversion_strobe <= 1'b0;
			o_strobe_oe <= 1'b0;
			o_pos_channel <= 3'd0;
			o_neg_channel <= 4'h8;
			o_bipolar <= 1'b0;
			o_int_clk_mode <= 1'b0;
			o_power_clock_sel <= `ADSP_PCS_EXT_CLK;
			o_track <= 1'b0;
			o_sample_req <= 1'b0;
			o_busy <= 1'b0;
		end else if (i_ce) begin
			sclk_prev_q <= sclk_s;
			o_sample_req <= 1'b0;
			o_result_oe <= ~cs_n_s; // RQ20
			o_strobe_oe <= ~cs_n_s | o_int_clk_mode;
			if (cs_n_s) begin
				// deselect ends the frame; a half-received byte is dropped
				st_q <= ST_IDLE; // RQ22
				nbit_q <= 3'd0; // RQ22
				o_conversion_strobe <= 1'b0;
				o_result_out <= 1'b0;
				o_track <= 1'b0;
				o_busy <= 1'b0;
			end else begin
				case (st_q)
				ST_IDLE: begin
					if (rise && cmd_s) begin
						st_q <= ST_CTRL; // RQ7
						shreg_q <= 7'd1; // RQ6
						nbit_q <= 3'd1;
					end
				end
				ST_CTRL: begin
					if (rise) begin
						shreg_q <= byte_w[6:0]; // RQ6
						nbit_q <= nbit_q + 3'd1;
						if (nbit_q == 3'd7) begin
							// full byte decoded msb first
							o_pos_channel <= pos_d; // RQ8 RQ2
							o_neg_channel <= neg_d;
							o_bipolar <= ~byte_w[`ADSP_BIT_POLARITY]; // RQ8
							o_power_clock_sel <= byte_w[1:0]; // RQ8
							o_int_clk_mode <= (byte_w[1:0] != `ADSP_PCS_EXT_CLK); // RQ19
							o_sample_req <= 1'b1;
							st_q <= ST_CONV;
							conv_cnt_q <= 4'd0;
						end
					end
					if (fall && nbit_q == `ADSP_TRACK_BIT) begin
						o_track <= 1'b1; // RQ21
					end
				end
				ST_CONV: begin
					if (fall) begin
						// saturate: extra clocks of a long host frame must not wrap and restart the strobe
						if (conv_cnt_q != 4'd15) begin
							conv_cnt_q <= conv_cnt_q + 4'd1;
						end
						if (conv_cnt_q == 4'd0) begin
							o_track <= 1'b0; // RQ21
							o_busy <= 1'b1;
							o_conversion_strobe <= ~o_int_clk_mode; // RQ3 RQ5
							// unipolar straight binary, bipolar flips the msb to twos complement
							res_q <= o_bipolar ? (i_sample_offset_bin ^ `ADSP_BIPOLAR_MID) :
								i_sample_offset_bin; // RQ17
							o_result_out <= 1'b0; // RQ15
						end else if (conv_cnt_q <= 4'd12) begin
							o_conversion_strobe <= 1'b0; // RQ3
							o_result_out <= res_q[RES_BITS-1]; // RQ18 RQ5
							res_q <= {res_q[RES_BITS-2:0], 1'b0}; // RQ18
						end else begin
							o_result_out <= 1'b0; // RQ15
							// frame of 8 + 13 clocks done: a new start may follow
							if (conv_cnt_q == 4'd13) begin
								o_busy <= 1'b0; // RQ4
							end
						end
					end
					// a start bit after result bit 6 is out begins the next frame
					if (rise && cmd_s && conv_cnt_q >= 4'd7) begin
						st_q <= ST_CTRL; // RQ4 RQ7
						shreg_q <= 7'd1;
						nbit_q <= 3'd1;
					end
				end
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// ### test/adsp_port_sva.sv
// checker on the pins of the adc serial port
`timescale 1ns/1ps
module adsp_port_sva (
	input wire i_clk, i_sys_rst, i_cs_n, i_sclk, o_result_out, o_result_oe, o_conversion_strobe,
	input wire o_strobe_oe, o_int_clk_mode, o_track, o_sample_req,
	input wire [2:0] o_pos_channel,
	input wire [3:0] o_neg_channel
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_rel; $rose(i_cs_n) |-> ##[1:10] !o_result_oe && !o_conversion_strobe; endproperty
	a_rel: assert property (p_rel) else $error("not released");
	property p_wide; $rose(o_conversion_strobe) |=> o_conversion_strobe[*8]; endproperty
	a_wide: assert property (p_wide) else $error("strobe short");
	property p_lead; o_conversion_strobe |-> !o_result_out; endproperty
	a_lead: assert property (p_lead) else $error("no leading zero");
	property p_ofall; o_result_oe && $past(o_result_oe) && $changed(o_result_out) |-> !i_sclk; endproperty
	a_ofall: assert property (p_ofall) else $error("data moved off fall");
	property p_sfall; o_strobe_oe && $changed(o_conversion_strobe) |-> !i_sclk; endproperty
	a_sfall: assert property (p_sfall) else $error("strobe moved off fall");
	property p_ext; o_sample_req ##1 !o_int_clk_mode |-> ##[1:24] $rose(o_conversion_strobe); endproperty
	a_ext: assert property (p_ext) else $error("no strobe");
	property p_pair; !o_neg_channel[3] |-> o_neg_channel[2:0] == (o_pos_channel ^ 3'h1); endproperty
	a_pair: assert property (p_pair) else $error("bad pair");
	property p_hold; $fell(o_track) |-> $rose(o_conversion_strobe); endproperty
	a_hold: assert property (p_hold) else $error("hold off time");
	c_strb: cover property ($rose(o_conversion_strobe));
	c_diff: cover property (o_sample_req ##1 !o_neg_channel[3]);
	c_rel: cover property ($rose(i_cs_n));
endmodule
bind adsp_port adsp_port_sva u_sva (.*);

// ### test/adsp_host.sv
// spi mode zero host: clock idles low, data set while it is low
`timescale 1ns/1ps
module adsp_host (
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_cmd,
	input wire i_miso
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_cmd = 1'b0;
	end
	task automatic frame(input logic [7:0] cb, input int z, input int m, output logic [15:0] rx);
		logic [23:0] d;
		d = {cb, 16'h0000};
		rx = 16'h0000;
		o_cs_n = 1'b0;
		#200;
		for (int i = 0; i < z + m; i++) begin
			o_cmd = (i < z) ? 1'b0 : d[23 - i + z];
			#62.5 o_sclk = 1'b1;
			rx = {rx[14:0], i_miso};
			#62.5 o_sclk = 1'b0;
		end
		#200 o_cs_n = 1'b1;
		// line is floating once deselected, so show a changed level
		o_cmd = ~o_cmd;
		#300;
	endtask
endmodule

// ### test/adsp_port_tb.sv
// self-checking bench for the adc serial control port
`timescale 1ns/1ps
module adsp_port_tb;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1;
	logic [11:0] i_sample_offset_bin = 12'h000;
	wire i_cs_n, i_sclk, i_cmd_in, miso, o_result_out, o_result_oe, o_conversion_strobe, o_strobe_oe;
	wire o_bipolar, o_int_clk_mode, o_track, o_sample_req, o_busy;
	wire [2:0] o_pos_channel;
	wire [3:0] o_neg_channel;
	wire [1:0] o_power_clock_sel;
	int num_errors = 0, compares = 0, cyc = 0;
	logic [15:0] rx;
	logic [7:0] cb;
	always #4 i_clk = ~i_clk;
	assign miso = o_result_oe ? o_result_out : 1'bz;
	adsp_host u_host (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_cmd(i_cmd_in), .i_miso(miso));
	adsp_port DUT (.*);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [15:0] exp_rx(input logic [7:0] c, input logic [11:0] s);
		return {1'b0, s ^ {~c[3], 11'h000}, 3'h0};
	endfunction
	function automatic logic [15:0] exp_dec(input logic [7:0] c);
		logic [2:0] p;
		p = {c[5], c[4], c[6]};
		return {p, c[2] ? 4'h8 : {1'b0, p ^ 3'h1}, ~c[3], c[1:0]};
	endfunction
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(1449));
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (8) @(posedge i_clk);
		u_host.frame(8'hb3, 0, 4, rx);
		chk("partial", {3'd0, 4'h8, 1'b0, 2'b11}, {o_pos_channel, o_neg_channel, o_bipolar, o_power_clock_sel});
		// all 32 middle-bit codes, the last one being the all-ones byte
		for (int k = 0; k < 32; k++) begin
			cb = {1'b1, k[4:0], 2'b11};
			@(posedge i_clk) i_sample_offset_bin <= 12'($urandom);
			u_host.frame(cb, $urandom_range(3, 0), 24, rx);
			chk("idle", 16'h0000, {o_busy, o_result_oe, o_conversion_strobe});
			chk("result", exp_rx(cb, i_sample_offset_bin), rx);
			chk("decode", exp_dec(cb), {o_pos_channel, o_neg_channel, o_bipolar, o_power_clock_sel});
		end
		print_verdict();
	end
endmodule
